// ---- rtl/cis_sequencer.sv ----
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Accept request only with local and global enable.
// - Lowest vector wins; reset highest, then source zero.
// - Taking an interrupt clears global enable.
// - Software may set global enable inside handler.
// - Return from handler sets global enable.
// - Flag source vectored and its flag cleared.
// - Writing one clears a flag; zero leaves it.
// - Disabled flag events stay held until serviced.
// - Level sources request only while present, unlatched.
// - One instruction runs after return before servicing.
// - Status register never saved or restored automatically.
// - Global disable blocks even a simultaneous request.
// - Instruction after global enable runs before servicing.
// - Entry takes four cycles pushing program counter.
// - Multi-cycle instruction finishes before entry starts.
// - Wake from sleep adds four entry cycles.
// - Return takes four cycles, pops two bytes.
// - Vector jump takes three clock cycles.
// - Core clock is the undivided input clock.
// - Single cycle register operation writes back same cycle.
// - Entry push lowers stack pointer by two.
// - Global enable is status bit seven, resets zero.
module cis_sequencer
   import cis_pkg::*;
(
   input  wire  logic                pclk,
   input  wire  logic                presetn,
   input  wire  logic                psel,
   input  wire  logic                penable,
   input  wire  logic                pwrite,
   input  wire  logic [31:0]         paddr,
   input  wire  logic [31:0]         pwdata,
   output var   logic [31:0]         prdata,
   output var   logic                pready,
   output var   logic                pslverr,
   input  wire  logic [NUM_SRC-1:0]  irq_src,
   input  wire  logic                instr_boundary,
   input  wire  logic                instr_enable_all,
   input  wire  logic                instr_disable_all,
   input  wire  logic                instr_return,
   input  wire  logic                status_we,
   input  wire  logic [7:0]          status_wdata,
   input  wire  logic                core_sleeping,
   input  wire  logic [8:0]          pc_in,
   input  wire  logic [7:0]          stack_rdata,
   output var   logic                stack_we,
   output var   logic                stack_re,
   output var   logic [7:0]          stack_addr,
   output var   logic [7:0]          stack_wdata,
   output var   logic                pc_load,
   output var   logic [8:0]          pc_load_addr,
   output var   logic                core_stall,
   output var   logic                vector_jump,
   output var   logic                irq_taken,
   output var   logic [7:0]          status_flags_reg,
   output var   logic [7:0]          stack_ptr
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Lowest index wins, so the lowest vector address has priority.
   function automatic logic [3:0] prio_pick(input logic [NUM_SRC-1:0] req);
      logic [3:0] pick;
      pick = 4'hf;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            pick = 4'(i);
         end
      end
      return pick;
   endfunction

   function automatic logic [NUM_SRC-1:0] onehot(input logic [3:0] idx);
      logic [NUM_SRC-1:0] v;
      v = '0;
      if (idx < 4'(NUM_SRC)) begin
         v[idx[2:0]] = 1'b1;
      end
      return v;
   endfunction

   // Vector address of a source; the reset vector sits below all of them.
   function automatic logic [8:0] vector_of(input logic [3:0] idx);
      return {5'h0, idx} + 9'h001;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   // The whole sequencer runs on pclk, which is the core clock itself.
   cis_state_e          state;
   logic [3:0]          step;
   logic [3:0]          seq_len;
   // The winner is latched at the take, so a request that arrives during
   // entry cannot redirect the vector that is loaded.
   logic [3:0]          vec_idx;
   logic [8:0]          saved_pc;
   logic [7:0]          pop_hi;
   logic [NUM_SRC-1:0]  enable;
   logic [NUM_SRC-1:0]  flags;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire logic       setup_ph  = psel & ~penable;
   wire logic       access_ph = psel & penable & pready;
   wire logic [7:0] widx      = paddr[9:2];
   wire logic       aligned   = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h0);
   wire logic       hit_en    = aligned && (widx == IDX_ENABLE);
   wire logic       hit_fl    = aligned && (widx == IDX_FLAGS);
   wire logic       hit_st    = aligned && (widx == IDX_STATE);
   wire logic       hit_sp    = aligned && (widx == IDX_STACK_PTR);
   wire logic       hit_sr    = aligned && (widx == IDX_STATUS);
   wire logic       hit_any   = hit_en | hit_fl | hit_st | hit_sp | hit_sr;
   wire logic       wr_ok     = access_ph & pwrite & hit_any;
   wire logic       wr_en     = wr_ok & hit_en;
   wire logic       wr_fl     = wr_ok & hit_fl;
   wire logic       wr_sp     = wr_ok & hit_sp;
   wire logic       wr_sr     = wr_ok & hit_sr;

   wire logic [31:0] rd_mux =
      hit_en ? {24'h0, enable} :
      hit_fl ? {24'h0, flags | (irq_src & LEVEL_MASK)} :
      hit_st ? {16'h0, 4'h0, vec_idx, 2'b00, 2'(state), step} :
      hit_sp ? {24'h0, stack_ptr} :
      hit_sr ? {24'h0, status_flags_reg} :
               32'h0;

   // ----------------------------------------------------------------
   // Request gating and arbitration
   // ----------------------------------------------------------------
   wire logic [NUM_SRC-1:0] pending = flags | (irq_src & LEVEL_MASK);
   wire logic [NUM_SRC-1:0] armed   = pending & enable;
   wire logic               gie     = status_flags_reg[GIE_BIT];
   wire logic [3:0]         pick    = prio_pick(armed);
   wire logic               at_run  = (state == CIS_RUN);
   // A boundary only arrives once a multi-cycle instruction is complete.
   wire logic               can_take = at_run & instr_boundary & ~instr_return;
   // The registered enable lags by one boundary, so the instruction after
   // an enable always completes first; a disable in this cycle vetoes.
   wire logic               take = can_take & gie & (|armed) & ~instr_disable_all;
   wire logic               start_ret = at_run & instr_boundary & instr_return;
   wire logic               last_step = (step == seq_len - 4'h1);
   wire logic               entry_end = (state == CIS_ENTRY) & last_step;
   wire logic               ret_end   = (state == CIS_RETURN) & last_step;
   wire logic [3:0]         entry_len = core_sleeping ? ENTRY_CYCLES + WAKE_EXTRA
                                                      : ENTRY_CYCLES;

   // Hardware clear of a flag source on vectoring; set still wins.
   wire logic [NUM_SRC-1:0] hw_clr  = take ? (onehot(pick) & ~LEVEL_MASK) : '0;
   wire logic [NUM_SRC-1:0] sw_clr  = wr_fl ? pwdata[NUM_SRC-1:0] : '0;
   wire logic [NUM_SRC-1:0] next_flags =
      (flags & ~hw_clr & ~sw_clr) | (irq_src & ~LEVEL_MASK);

   // ----------------------------------------------------------------
   // Status register
   // ----------------------------------------------------------------
   // Only the enable bit is ever touched by sequencing; the other bits
   // keep whatever the pipeline or software last wrote, since the handler
   // is responsible for preserving them.
   wire logic [7:0] sr_wr_val = wr_sr     ? pwdata[7:0] :
                                status_we ? status_wdata :
                                            status_flags_reg;
   wire logic       next_gie  = take              ? 1'b0 :
                                ret_end           ? 1'b1 :
                                instr_disable_all ? 1'b0 :
                                instr_enable_all  ? 1'b1 :
                                                    sr_wr_val[GIE_BIT];
   wire logic [7:0] next_status =
      {next_gie, sr_wr_val[GIE_BIT-1:0]};

   // ----------------------------------------------------------------
   // Sequencer next state
   // ----------------------------------------------------------------
   cis_state_e next_state;
   logic [3:0] next_step;
   logic [3:0] next_len;
   always_comb begin
      next_state = state;
      next_step  = step + 4'h1;
      next_len   = seq_len;
      case (state)
         CIS_RUN: begin
            next_step = 4'h0;
            if (start_ret) begin
               next_state = CIS_RETURN;
               next_len   = RETURN_CYCLES;
            end else if (take) begin
               next_state = CIS_ENTRY;
               next_len   = entry_len;
            end
         end
         CIS_ENTRY: begin
            if (last_step) begin
               next_state = CIS_JUMP;
               next_step  = 4'h0;
               next_len   = JUMP_CYCLES;
            end
         end
         CIS_JUMP, CIS_RETURN: begin
            if (last_step) begin
               next_state = CIS_RUN;
               next_step  = 4'h0;
            end
         end
         default: begin
            next_state = CIS_RUN;
            next_step  = 4'h0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Stack port
   // ----------------------------------------------------------------
   wire logic       in_entry   = (state == CIS_ENTRY);
   wire logic       in_ret     = (state == CIS_RETURN);
   wire logic       push_now   = in_entry & (step < 4'h2);
   wire logic       pop_now    = in_ret & (step < 4'h2);
   wire logic [7:0] push_addr  = stack_ptr - {7'h0, step[0]};
   wire logic [7:0] pop_addr   = stack_ptr + {6'h0, step[1:0]} + 8'h01;
   wire logic [7:0] push_data  = step[0] ? {7'h0, saved_pc[8]} : saved_pc[7:0];
   // Entry pushes low byte first, so return pops high byte first.
   wire logic [7:0] next_sp    =
      entry_end ? stack_ptr - RET_ADDR_BYTES :
      ret_end   ? stack_ptr + RET_ADDR_BYTES :
      wr_sp     ? pwdata[7:0] :
                  stack_ptr;
   // The low byte is taken straight off the stack bus in the last step,
   // the same cycle in which the return address is loaded.
   wire logic [8:0] ret_pc     = {pop_hi[0], stack_rdata};

   wire logic       next_pc_load = entry_end | ret_end;
   wire logic [8:0] next_pc_addr = entry_end ? vector_of(vec_idx) :
                                   ret_end   ? ret_pc :
                                               pc_load_addr;
   wire logic       next_stall   = (next_state != CIS_RUN);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= CIS_RUN;
         step    <= 4'h0;
         seq_len <= 4'h1;
      end else begin
         state   <= next_state;
         step    <= next_step;
         seq_len <= next_len;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable           <= ENABLE_RESET;
         flags            <= '0;
         status_flags_reg <= STATUS_RESET;
         stack_ptr        <= SP_RESET;
      end else begin
         enable           <= wr_en ? pwdata[NUM_SRC-1:0] : enable;
         flags            <= next_flags;
         status_flags_reg <= next_status;
         stack_ptr        <= next_sp;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_idx  <= 4'h0;
         saved_pc <= 9'h000;
      end else if (take) begin
         vec_idx  <= pick;
         saved_pc <= pc_in;
      end
   end

   // The stack answers one cycle after the registered read strobe, so the
   // high byte stands on the bus during step two and the low byte during
   // the last step. Holding the low byte in a register as well would make
   // it arrive one cycle after the program counter load that needs it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pop_hi <= 8'h00;
      end else begin
         pop_hi <= (in_ret && step == 4'h2) ? stack_rdata : pop_hi;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stack_we    <= 1'b0;
         stack_re    <= 1'b0;
         stack_addr  <= SP_RESET;
         stack_wdata <= 8'h00;
      end else begin
         stack_we    <= push_now;
         stack_re    <= pop_now;
         stack_addr  <= push_now ? push_addr : pop_now ? pop_addr : stack_addr;
         stack_wdata <= push_now ? push_data : stack_wdata;
      end
   end

   // After reset the pipeline is pointed at the reset vector once.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_load      <= 1'b1;
         pc_load_addr <= RESET_VECTOR;
         core_stall   <= 1'b0;
         vector_jump  <= 1'b0;
         irq_taken    <= 1'b0;
      end else begin
         pc_load      <= next_pc_load;
         pc_load_addr <= next_pc_addr;
         core_stall   <= next_stall;
         vector_jump  <= (next_state == CIS_JUMP);
         irq_taken    <= take;
      end
   end

   // Zero-wait slave: ready comes in the access phase after every setup.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph & ~hit_any;
         prdata  <= (setup_ph && !pwrite) ? rd_mux : 32'h0;
      end
   end

endmodule

`default_nettype wire

// ---- rtl/cis_pkg.sv ----
package cis_pkg;

   // ----------------------------------------------------------------
   // Register map (word indices; byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int         NUM_SRC        = 8;
   localparam logic [7:0] IDX_ENABLE     = 8'h00;
   localparam logic [7:0] IDX_FLAGS      = 8'h01;
   localparam logic [7:0] IDX_STATE      = 8'h02;
   localparam logic [7:0] IDX_STACK_PTR  = 8'h03;
   localparam logic [7:0] IDX_STATUS     = 8'h3f;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int         GIE_BIT        = 7;
   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [7:0] ENABLE_RESET   = 8'h00;
   localparam logic [7:0] SP_RESET       = 8'h9f;
   localparam logic [7:0] LEVEL_MASK     = 8'hc0;
   localparam logic [8:0] RESET_VECTOR   = 9'h000;

   // ----------------------------------------------------------------
   // Sequence lengths in core clock cycles, and return address size in bytes
   // ----------------------------------------------------------------
   localparam logic [3:0] ENTRY_CYCLES   = 4'h4;
   localparam logic [3:0] WAKE_EXTRA     = 4'h4;
   localparam logic [3:0] RETURN_CYCLES  = 4'h4;
   localparam logic [3:0] JUMP_CYCLES    = 4'h3;
   localparam logic [7:0] RET_ADDR_BYTES = 8'h02;

   typedef enum logic [1:0] {
      CIS_RUN,
      CIS_ENTRY,
      CIS_JUMP,
      CIS_RETURN
   } cis_state_e;

endpackage

// ---- bench/cis_sequencer_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------
// Entry, jump and return timing checks, and global enable gating checks.
// ------
module cis_sequencer_chk (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       instr_boundary,
   input wire logic       instr_enable_all,
   input wire logic       instr_disable_all,
   input wire logic       instr_return,
   input wire logic       core_sleeping,
   input wire logic       stack_we,
   input wire logic       pc_load,
   input wire logic       core_stall,
   input wire logic       vector_jump,
   input wire logic       irq_taken,
   input wire logic [7:0] status_flags_reg,
   input wire logic [7:0] stack_ptr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_take_gie: assert property (
      irq_taken |-> $past(status_flags_reg[7]) && !status_flags_reg[7])
      else $error("take not gated or global enable left set");
   a_push_pair: assert property (
      irq_taken |=> stack_we ##1 stack_we ##1 !stack_we)
      else $error("return address push is not two bytes");
   a_entry_four: assert property (
      irq_taken && !$past(core_sleeping) |-> !pc_load[*4] ##1 pc_load)
      else $error("entry is not four cycles");
   a_wake_eight: assert property (
      irq_taken && $past(core_sleeping) |-> !pc_load[*8] ##1 pc_load)
      else $error("wake entry is not eight cycles");
   a_jump_three: assert property (
      $rose(vector_jump) |-> vector_jump[*3] ##1 !vector_jump)
      else $error("vector jump is not three cycles");
   a_push_sp_two: assert property (
      $rose(vector_jump) |-> stack_ptr == $past(stack_ptr) - 8'h02)
      else $error("entry did not lower stack pointer by two");
   a_return_four: assert property (
      instr_boundary && instr_return && !core_stall |=> core_stall[*4] ##1
      (!core_stall && pc_load && status_flags_reg[7] && stack_ptr == $past(stack_ptr, 5) + 8'h02))
      else $error("return sequence wrong");
   a_disable_veto: assert property (
      instr_boundary && instr_disable_all |=> !irq_taken)
      else $error("interrupt taken at global disable");
   a_enable_defer: assert property (
      instr_boundary && instr_enable_all && !status_flags_reg[7] |=> !irq_taken)
      else $error("interrupt taken at global enable");
endmodule
`default_nettype wire

// ---- bench/cis_stack_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ------
// Stack memory on the pipeline side.
// ------
// Outside a read the data lines flip every cycle, so a pop sampled in
// the wrong cycle cannot pass by luck.
module cis_stack_model (
   input  wire logic       pclk,
   input  wire logic       stack_we,
   input  wire logic       stack_re,
   input  wire logic [7:0] stack_addr,
   input  wire logic [7:0] stack_wdata,
   output var  logic [7:0] stack_rdata
);
   logic [7:0] mem [256];
   initial stack_rdata = 8'h5a;
   always @(posedge pclk) begin
      if (stack_we)
         mem[stack_addr] <= stack_wdata;
      stack_rdata <= stack_re ? mem[stack_addr] : ~stack_rdata;
   end
endmodule
`default_nettype wire

// ---- bench/tb_cpu_interrupt_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_interrupt_sequencer
   import cis_pkg::*;
;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0]        paddr, pwdata, prdata;
   logic [NUM_SRC-1:0] irq_src;
   logic               instr_boundary, instr_enable_all, instr_disable_all, instr_return;
   logic               status_we, core_sleeping, stack_we, stack_re, pc_load;
   logic               core_stall, vector_jump, irq_taken;
   logic [7:0]         status_wdata, stack_rdata, stack_addr, stack_wdata;
   logic [7:0]         status_flags_reg, stack_ptr, s;
   logic [8:0]         pc_in, pc_load_addr, pa, pb;
   logic [16:0]        lfsr;
   logic [32:0]        rd_q [$];
   logic [8:0]         pc_q [$];
   int                 miscompares, check_count;
   cis_sequencer i_dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq_src, .instr_boundary, .instr_enable_all, .instr_disable_all,
      .instr_return, .status_we, .status_wdata, .core_sleeping, .pc_in, .stack_rdata,
      .stack_we, .stack_re, .stack_addr, .stack_wdata, .pc_load, .pc_load_addr,
      .core_stall, .vector_jump, .irq_taken, .status_flags_reg, .stack_ptr);
   cis_stack_model i_stack (.pclk, .stack_we, .stack_re, .stack_addr, .stack_wdata, .stack_rdata);
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // ------
   // Helpers.
   // ------
   function automatic logic [16:0] next_rand(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction
   function automatic logic [31:0] ad(input logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [32:0] g, input logic [32:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic rd(input logic [31:0] a, input logic [32:0] e);
      rd_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic step(input logic en, input logic dis, input logic ret);
      @(posedge pclk);
      {instr_boundary, instr_enable_all, instr_disable_all, instr_return} <= {1'b1, en, dis, ret};
      @(posedge pclk);
      {instr_boundary, instr_enable_all, instr_disable_all, instr_return} <= 4'h0;
   endtask
   // A take or a return ends only when its load is seen and the stall is gone.
   task automatic go(input logic [8:0] e, input logic ret);
      int n;
      pc_q.push_back(e);
      step(1'b0, 1'b0, ret);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((pc_q.size() != 0 || core_stall !== 1'b0) && n < 40);
      if (n >= 40) begin
         miscompares++;
         give_verdict();
      end
   endtask
   task automatic pulse(input logic [7:0] m);
      @(posedge pclk);
      irq_src <= m;
      @(posedge pclk);
      irq_src <= 8'h00;
   endtask
   // An empty queue compares against unknown, so any unasked load fails.
   always @(posedge pclk) begin
      if (presetn === 1'b1 && psel && penable && pready === 1'b1 && !pwrite)
         cmp({pslverr, prdata}, rd_q.size() != 0 ? rd_q.pop_front() : 'x);
      if (presetn === 1'b1 && pc_load === 1'b1)
         cmp({24'h0, pc_load_addr}, pc_q.size() != 0 ? {24'h0, pc_q.pop_front()} : 'x);
   end
   // ------
   // Main sequence.
   // ------
   initial begin
      {psel, penable, pwrite, paddr, pwdata, irq_src, status_we, status_wdata} = '0;
      {instr_boundary, instr_enable_all, instr_disable_all, instr_return} = '0;
      {core_sleeping, pc_in, miscompares, check_count} = '0;
      lfsr = 17'h17163;
      presetn = 1'b0;
      pc_q.push_back(RESET_VECTOR);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(ad(IDX_STATUS), {25'h0, STATUS_RESET});
      rd(ad(IDX_STACK_PTR), {25'h0, SP_RESET});
      rd(ad(IDX_ENABLE), {25'h0, ENABLE_RESET});
      rd(32'h0000_0010, {1'b1, 32'h0});
      lfsr = next_rand(lfsr);
      s = {1'b0, lfsr[6:0]};
      status_we <= 1'b1;
      status_wdata <= s;
      @(posedge pclk);
      status_we <= 1'b0;
      rd(ad(IDX_STATUS), {25'h0, s});
      pulse(8'h0a);
      step(1'b0, 1'b0, 1'b0);
      rd(ad(IDX_FLAGS), {25'h0, 8'h0a});
      apb(1'b1, ad(IDX_ENABLE), 32'h0000_00ff);
      step(1'b0, 1'b0, 1'b0);
      lfsr = next_rand(lfsr);
      pa = lfsr[8:0];
      pc_in <= pa;
      step(1'b1, 1'b0, 1'b0);
      go(9'h002, 1'b0);
      rd(ad(IDX_FLAGS), {25'h0, 8'h08});
      rd(ad(IDX_STATE), {1'b0, 32'h0000_0100});
      rd(ad(IDX_STATUS), {25'h0, s});
      lfsr = next_rand(lfsr);
      pb = lfsr[8:0];
      pc_in <= pb;
      step(1'b1, 1'b0, 1'b0);
      go(9'h004, 1'b0);
      pulse(8'h20);
      go(pb, 1'b1);
      go(9'h006, 1'b0);
      go(pb, 1'b1);
      go(pa, 1'b1);
      apb(1'b1, ad(IDX_ENABLE), 32'h0);
      pulse(8'h14);
      apb(1'b1, ad(IDX_FLAGS), 32'h0000_0004);
      rd(ad(IDX_FLAGS), {25'h0, 8'h10});
      apb(1'b1, ad(IDX_FLAGS), 32'h0);
      rd(ad(IDX_FLAGS), {25'h0, 8'h10});
      apb(1'b1, ad(IDX_FLAGS), 32'h0000_0010);
      apb(1'b1, ad(IDX_ENABLE), 32'h0000_00ff);
      irq_src <= 8'h40;
      rd(ad(IDX_FLAGS), {25'h0, 8'h40});
      irq_src <= 8'h00;
      rd(ad(IDX_FLAGS), {25'h0, 8'h00});
      step(1'b0, 1'b0, 1'b0);
      irq_src <= 8'h80;
      step(1'b0, 1'b1, 1'b0);
      rd(ad(IDX_STATUS), {25'h0, s});
      lfsr = next_rand(lfsr);
      pa = lfsr[8:0];
      pc_in <= pa;
      core_sleeping <= 1'b1;
      step(1'b1, 1'b0, 1'b0);
      go(9'h008, 1'b0);
      irq_src <= 8'h00;
      core_sleeping <= 1'b0;
      go(pa, 1'b1);
      give_verdict();
   end
endmodule
bind cis_sequencer cis_sequencer_chk i_chk (
   .pclk, .presetn, .instr_boundary, .instr_enable_all, .instr_disable_all, .instr_return,
   .core_sleeping, .stack_we, .pc_load, .core_stall, .vector_jump, .irq_taken,
   .status_flags_reg, .stack_ptr);
`default_nettype wire
